// File: rtl/dcff_pkg.sv
// Contract
// - every flag passes two port-clock synchroniser stages
// - flag levels follow the stored word count table
// - word in output register counts as read
// - ready low keeps old word, reads ignored
// - read pointer steps on each output load except a retransmit reload
// - first word appears on third read edge
// - late read edge delays synchronisation by one
// - input ready high while a location is free
// - input ready rises two write edges after read
// - late write edge delays synchronisation by one
// - almost empty low at X or fewer words
// - almost empty rises two read edges after write
// - almost full low at 2048 minus Y or more
// - almost full rises two write edges after read
// - retransmit mode entered with mode input and ready
// - read from mark reloads marked word after two reads
// - shadow pointer feeds write side flags in mode
// - writes continue, full counted from marked word
// - retransmit copies shadow, ready updates at once
// - mode exit returns write flags to current pointer
// - empty output register loads next word automatically
// - offsets X and Y lie in 1 to 2044
package dcff_pkg;

	localparam int AW = 11;
	localparam int PW = 12;
	localparam int DW = 36;
	localparam int DEPTH = 2048;

	localparam logic [PW-1:0] FIFO_WORDS     = 12'h800;
	localparam logic [PW-1:0] PTR_ONE        = 12'h001;
	localparam logic [AW-1:0] OFS_MIN        = 11'h001;
	localparam logic [AW-1:0] OFS_MAX        = 11'h7FC;
	localparam logic [AW-1:0] OFS_X_RESET    = 11'h008;
	localparam logic [AW-1:0] OFS_Y_RESET    = 11'h008;
	localparam logic [1:0]    RETX_MIN_READS = 2'h2;

	// register map, byte addresses
	localparam logic [11:0] ADDR_OFS_X  = 12'h000;
	localparam logic [11:0] ADDR_OFS_Y  = 12'h004;
	localparam logic [11:0] ADDR_STATUS = 12'h008;

	// status word fields
	localparam int ST_READY        = 0;
	localparam int ST_ALMOST_EMPTY = 1;
	localparam int ST_ALMOST_FULL  = 2;
	localparam int ST_INPUT_READY  = 3;
	localparam int ST_RETX_MODE    = 4;
	localparam int ST_FILL_LSB     = 16;

	typedef struct packed {
		logic          psel;
		logic          penable;
		logic          pwrite;
		logic [11:0]   paddr;
		logic [31:0]   pwdata;
	} dcff_apb_req_t;

	typedef struct packed {
		logic [31:0]   prdata;
		logic          pready;
		logic          pslverr;
	} dcff_apb_rsp_t;

	typedef struct packed {
		logic          write_port_clock;
		logic          write_side_select_n;
		logic          write_port_direction;
		logic          write_side_strobe_gate;
		logic          write_side_mailbox_pick;
		logic [DW-1:0] data;
	} dcff_wport_t;

	typedef struct packed {
		logic          read_port_clock;
		logic          read_side_select_n;
		logic          read_port_direction;
		logic          read_side_strobe_gate;
		logic          read_side_mailbox_pick;
		logic          retransmit_mode_in;
		logic          read_from_mark;
	} dcff_rport_t;

	typedef struct packed {
		logic          output_ready;
		logic          almost_empty_flag;
		logic          almost_full_flag;
		logic          input_ready;
	} dcff_flags_t;

	typedef struct packed {
		dcff_wport_t   w1;
		dcff_wport_t   w2;
		dcff_rport_t   r1;
		dcff_rport_t   r2;
		logic          wclk_d;
		logic          rclk_d;
		logic [PW-1:0] wptr;
		logic [PW-1:0] wptr_gray;
		logic [PW-1:0] wq1;
		logic [PW-1:0] wq2;
		logic [PW-1:0] rptr;
		logic [PW-1:0] shadow;
		logic [PW-1:0] rpub_gray;
		logic [PW-1:0] rq1;
		logic [PW-1:0] rq2;
		logic          retx_mode;
		logic [1:0]    reads_since_mark;
		logic [DW-1:0] dout;
		dcff_flags_t   flags;
		logic [AW-1:0] ofs_x;
		logic [AW-1:0] ofs_y;
		dcff_apb_rsp_t rsp;
	} dcff_state_t;

	localparam dcff_state_t STATE_RESET = '{
		ofs_x: OFS_X_RESET,
		ofs_y: OFS_Y_RESET,
		default: '0
	};

	function automatic logic [PW-1:0] dcff_b2g(input logic [PW-1:0] b);
		dcff_b2g = b ^ (b >> 1);
	endfunction : dcff_b2g

	function automatic logic [PW-1:0] dcff_g2b(input logic [PW-1:0] g);
		logic [PW-1:0] b;
		b = '0;
		b[PW-1] = g[PW-1];
		for (int i = PW - 2; i >= 0; i--) begin
			b[i] = b[i+1] ^ g[i];
		end
		dcff_g2b = b;
	endfunction : dcff_g2b

endpackage : dcff_pkg

// File: rtl/dcff_core.sv
// Register access over APB and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none

module dcff_core (
	// clock and reset
	input  wire logic                      pclk,
	input  wire logic                      presetn,
	// register bus
	input  wire dcff_pkg::dcff_apb_req_t   apb_req,
	output var  dcff_pkg::dcff_apb_rsp_t   apb_rsp,
	// write port pins
	input  wire dcff_pkg::dcff_wport_t     wport,
	// read port pins
	input  wire dcff_pkg::dcff_rport_t     rport,
	output var  logic [dcff_pkg::DW-1:0]   read_data,
	// status flags
	output var  dcff_pkg::dcff_flags_t     flags
);

	////////////////////////////////////////////////////////////////////////////
	// state

	dcff_pkg::dcff_state_t          s;
	dcff_pkg::dcff_state_t          next_s;
	logic [dcff_pkg::DW-1:0]        mem [dcff_pkg::DEPTH];

	logic                           we;
	logic                           re;
	logic                           wr_fire;
	logic                           rd_fire;
	logic                           avail;
	logic                           retx;
	logic                           load_normal;
	logic [dcff_pkg::PW-1:0]        fill_w;
	logic [dcff_pkg::PW-1:0]        fill_r;
	logic                           acc;
	logic                           ofs_ok;
	logic [31:0]                    status;

	////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		next_s = s;
		// pins pass two flops before use; the port clocks are sampled like data
		next_s.w1 = wport;
		next_s.w2 = s.w1;
		next_s.r1 = rport;
		next_s.r2 = s.r1;
		next_s.wclk_d = s.w2.write_port_clock;
		next_s.rclk_d = s.r2.read_port_clock;
		we = s.w2.write_port_clock & ~s.wclk_d;
		re = s.r2.read_port_clock & ~s.rclk_d;

		// write side
		wr_fire = we & ~s.w2.write_side_select_n & s.w2.write_port_direction
			& s.w2.write_side_strobe_gate & ~s.w2.write_side_mailbox_pick
			& s.flags.input_ready;
		if (we) begin
			// the read pointer arrives in gray code, one bit moves per step except at retransmit mode exit, where it jumps from shadow to read pointer
			next_s.wq1 = s.rpub_gray;
			next_s.wq2 = s.wq1;
		end
		if (wr_fire) begin
			next_s.wptr = s.wptr + dcff_pkg::PTR_ONE;
			next_s.wptr_gray = dcff_pkg::dcff_b2g(next_s.wptr);
		end
		// flags judged against the second stage only; full bites on the write itself
		fill_w = next_s.wptr - dcff_pkg::dcff_g2b(s.wq2);
		next_s.flags.input_ready = fill_w < dcff_pkg::FIFO_WORDS;
		next_s.flags.almost_full_flag =
			fill_w < (dcff_pkg::FIFO_WORDS - {1'b0, s.ofs_y});

		// read side
		if (re) begin
			next_s.rq1 = s.wptr_gray;
			next_s.rq2 = s.rq1;
		end
		// third read edge: rq1, rq2, then the load
		avail = dcff_pkg::dcff_g2b(s.rq2) != s.rptr;
		rd_fire = re & ~s.r2.read_side_select_n & s.r2.read_port_direction
			& s.r2.read_side_strobe_gate & ~s.r2.read_side_mailbox_pick
			& s.flags.output_ready;
		retx = re & s.retx_mode & s.r2.read_from_mark
			& (s.reads_since_mark == dcff_pkg::RETX_MIN_READS);
		load_normal = 1'b0;
		if (retx) begin
			next_s.dout = mem[s.shadow[dcff_pkg::AW-1:0]];
			next_s.rptr = s.shadow + dcff_pkg::PTR_ONE;
			next_s.flags.output_ready = 1'b1;
			next_s.reads_since_mark = '0;
		end else if (re & (~s.flags.output_ready | rd_fire)) begin
			if (avail) begin
				// loaded word leaves memory; outside retransmit mode its slot is free at once
				next_s.dout = mem[s.rptr[dcff_pkg::AW-1:0]];
				next_s.rptr = s.rptr + dcff_pkg::PTR_ONE;
				next_s.flags.output_ready = 1'b1;
				load_normal = 1'b1;
				if (s.retx_mode & (s.reads_since_mark != dcff_pkg::RETX_MIN_READS)) begin
					next_s.reads_since_mark = s.reads_since_mark + 2'h1;
				end
			end else begin
				next_s.flags.output_ready = 1'b0;
			end
		end
		if (re & ~s.retx_mode & s.r2.retransmit_mode_in & s.flags.output_ready) begin
			// mark the word sitting in the output register
			next_s.retx_mode = 1'b1;
			next_s.shadow = s.rptr - dcff_pkg::PTR_ONE;
			next_s.reads_since_mark = load_normal ? 2'h1 : 2'h0;
		end else if (re & s.retx_mode & ~s.r2.retransmit_mode_in) begin
			// assumes read from mark is low here, a reload would still be honoured
			next_s.retx_mode = 1'b0;
		end
		next_s.rpub_gray = dcff_pkg::dcff_b2g(next_s.retx_mode ? next_s.shadow
			: next_s.rptr);
		fill_r = dcff_pkg::dcff_g2b(s.rq2) - next_s.rptr
			+ {{(dcff_pkg::PW-1){1'b0}}, next_s.flags.output_ready};
		next_s.flags.almost_empty_flag = fill_r > {1'b0, s.ofs_x};

		// register bus: one wait state, answer from flops
		acc = apb_req.psel & apb_req.penable;
		ofs_ok = (apb_req.pwdata[dcff_pkg::AW-1:0] >= dcff_pkg::OFS_MIN)
			& (apb_req.pwdata[dcff_pkg::AW-1:0] <= dcff_pkg::OFS_MAX);
		status = '0;
		status[dcff_pkg::ST_READY] = s.flags.output_ready;
		status[dcff_pkg::ST_ALMOST_EMPTY] = s.flags.almost_empty_flag;
		status[dcff_pkg::ST_ALMOST_FULL] = s.flags.almost_full_flag;
		status[dcff_pkg::ST_INPUT_READY] = s.flags.input_ready;
		status[dcff_pkg::ST_RETX_MODE] = s.retx_mode;
		status[dcff_pkg::ST_FILL_LSB +: dcff_pkg::PW] = fill_r;
		next_s.rsp = '0;
		if (acc & ~s.rsp.pready) begin
			next_s.rsp.pready = 1'b1;
			unique case (apb_req.paddr)
				dcff_pkg::ADDR_OFS_X: begin
					next_s.rsp.prdata = {21'h000000, s.ofs_x};
					next_s.rsp.pslverr = apb_req.pwrite & ~ofs_ok;
				end
				dcff_pkg::ADDR_OFS_Y: begin
					next_s.rsp.prdata = {21'h000000, s.ofs_y};
					next_s.rsp.pslverr = apb_req.pwrite & ~ofs_ok;
				end
				dcff_pkg::ADDR_STATUS: begin
					next_s.rsp.prdata = status;
					next_s.rsp.pslverr = apb_req.pwrite;
				end
				default: begin
					next_s.rsp.pslverr = 1'b1;
				end
			endcase
		end
		// the write lands on the edge that completes the access
		if (acc & s.rsp.pready & apb_req.pwrite & ~s.rsp.pslverr) begin
			if (apb_req.paddr == dcff_pkg::ADDR_OFS_X) begin
				next_s.ofs_x = apb_req.pwdata[dcff_pkg::AW-1:0];
			end
			if (apb_req.paddr == dcff_pkg::ADDR_OFS_Y) begin
				next_s.ofs_y = apb_req.pwdata[dcff_pkg::AW-1:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= dcff_pkg::STATE_RESET;
		end else begin
			s <= next_s;
		end
	end

	// storage array has no reset; contents are only read after being written
	always_ff @(posedge pclk) begin
		if (wr_fire) begin
			mem[s.wptr[dcff_pkg::AW-1:0]] <= s.w2.data;
		end
	end

	assign apb_rsp   = s.rsp;
	assign read_data = s.dout;
	assign flags     = s.flags;

endmodule : dcff_core

`default_nettype wire

// File: bench/dcff_core_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module dcff_core_checker (
	// clock and reset
	input wire logic                    pclk,
	input wire logic                    presetn,
	// watched ports
	input wire dcff_pkg::dcff_apb_req_t apb_req,
	input wire dcff_pkg::dcff_apb_rsp_t apb_rsp,
	input wire dcff_pkg::dcff_wport_t   wport,
	input wire dcff_pkg::dcff_rport_t   rport,
	input wire logic [35:0]             read_data,
	input wire dcff_pkg::dcff_flags_t   flags
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	////////////////////////////////////////////////////////////////
	a_pready_pulse: assert property (apb_rsp.pready |=> !apb_rsp.pready)
		else $error("pready held too long");
	a_one_wait: assert property ($rose(apb_req.penable) && apb_req.psel |=> apb_rsp.pready)
		else $error("apb answer late");
	a_idle_zero: assert property (!apb_rsp.pready |-> apb_rsp.prdata == 0 && !apb_rsp.pslverr)
		else $error("apb answer outside pready");
	a_err_ready: assert property (apb_rsp.pslverr |-> apb_rsp.pready)
		else $error("pslverr without pready");
	a_data_hold: assert property ($changed(read_data) |-> flags.output_ready)
		else $error("read data changed without output ready");
	a_full_flag_order: assert property (!flags.input_ready |-> !flags.almost_full_flag)
		else $error("full without almost full");
	a_almost_full_room: assert property (flags.almost_full_flag |-> flags.input_ready)
		else $error("almost full high while full");
	a_almost_empty_ready: assert property (flags.almost_empty_flag |-> flags.output_ready)
		else $error("almost empty high while empty");
endmodule : dcff_core_checker
bind dcff_core dcff_core_checker i_chk (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
	.apb_rsp(apb_rsp), .wport(wport), .rport(rport), .read_data(read_data), .flags(flags));
`default_nettype wire

// File: bench/dcff_port_clocks.sv
`timescale 1ns/1ps
`default_nettype none
module dcff_port_clocks (
	// system clock
	input  wire logic pclk,
	// free-running port clocks
	output var  logic wclk,
	output var  logic rclk
);
	int wc = 0;
	int rc = 0;
	// unequal periods keep the ports out of step; both run free, never stopped
	always_ff @(posedge pclk) begin
		wc <= (wc == 7) ? 0 : wc + 1;
		rc <= (rc == 9) ? 0 : rc + 1;
	end
	assign wclk = (wc < 4);
	assign rclk = (rc < 5);
endmodule : dcff_port_clocks
`default_nettype wire

// File: bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic                    pclk;
	logic                    presetn;
	dcff_pkg::dcff_apb_req_t apb_req;
	dcff_pkg::dcff_apb_rsp_t apb_rsp;
	dcff_pkg::dcff_wport_t   wport;
	dcff_pkg::dcff_rport_t   rport;
	dcff_pkg::dcff_flags_t   flags;
	logic [35:0]             read_data;
	logic                    wclk;
	logic                    rclk;
	logic [3:0]              wctl;
	logic [5:0]              rctl;
	logic [35:0]             wdat;
	logic [35:0]             q[$];
	logic [35:0]             m[$];
	logic [35:0]             last;
	logic [31:0]             rd;
	logic                    er;
	int                      error_cnt = 0;
	int                      checked = 0;
	assign wport = {wclk, wctl, wdat};
	assign rport = {rclk, rctl};
	initial pclk = 1'b0;
	always #20 pclk = ~pclk;
	dcff_core i_dut (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
		.wport(wport), .rport(rport), .read_data(read_data), .flags(flags));
	dcff_port_clocks i_clk (.pclk(pclk), .wclk(wclk), .rclk(rclk));
	////////////////////////////////////////////////////////////////
	task cmp_data(input logic [35:0] got, input logic [35:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: read data %h expected %h", $time, got, exp);
		end
	endtask : cmp_data
	task cmp_reg(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: register word %h expected %h", $time, got, exp);
		end
	endtask : cmp_reg
	task cmp_flags(input dcff_pkg::dcff_flags_t got, input logic [3:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: flags %b expected %b", $time, got, exp);
		end
	endtask : cmp_flags
	task cmp_bit(input logic got, input logic exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: status bit %b expected %b", $time, got, exp);
		end
	endtask : cmp_bit
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		apb_req <= '{1'b1, 1'b0, w, a, d};
		@(posedge pclk);
		apb_req.penable <= 1'b1;
		do @(posedge pclk); while (apb_rsp.pready !== 1'b1);
		rd = apb_rsp.prdata;
		er = apb_rsp.pslverr;
		apb_req <= '0;
	endtask : apb
	// controls move only at a falling port clock, so they stand still around the rise
	task wr(input logic [3:0] c, input logic keep);
		@(negedge wclk);
		wdat <= 36'({$urandom, $urandom});
		wctl <= c;
		@(negedge wclk);
		wctl <= 4'h8;
		if (keep) q.push_back(wdat);
	endtask : wr
	// exactly one read clock rise sees c; then deselect, keeping only the mode input
	task rd_edge(input logic [5:0] c);
		@(negedge rclk);
		rctl <= c;
		@(negedge rclk);
		rctl <= {4'h8, c[1], 1'b0};
		@(negedge pclk);
	endtask : rd_edge
	task finish_test;
		$display("checked %0d error_cnt %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : finish_test
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (95000) @(posedge pclk);
		error_cnt++;
		finish_test();
	end
	initial begin
		presetn = 1'b0;
		apb_req = '0;
		wctl = 4'h8;
		rctl = 6'h20;
		wdat = '0;
		void'($urandom(26592));
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 12'h008, 32'h0);
		cmp_reg(rd, 32'h0000000C);
		apb(1'b1, 12'h004, 32'h0);
		cmp_bit(er, 1'b1);
		apb(1'b1, 12'h004, 32'h7FD);
		cmp_bit(er, 1'b1);
		apb(1'b1, 12'h00C, 32'h1);
		cmp_bit(er, 1'b1);
		apb(1'b1, 12'h008, 32'h1);
		cmp_bit(er, 1'b1);
		apb(1'b1, 12'h004, 32'h7FC);
		cmp_bit(er, 1'b0);
		apb(1'b1, 12'h000, 32'h4);
		cmp_bit(er, 1'b0);
		apb(1'b0, 12'h004, 32'h0);
		cmp_reg(rd, 32'h000007FC);
		wr(4'h7, 1'b0);
		wr(4'h6, 1'b1);
		cmp_flags(flags, 4'b0011);
		while (flags.input_ready === 1'b1) wr(4'h6, 1'b1);
		wr(4'h6, 1'b0);
		repeat (40) @(posedge pclk);
		cmp_reg(32'(q.size()), 32'h00000801);
		cmp_flags(flags, 4'b1100);
		apb(1'b0, 12'h008, 32'h0);
		cmp_reg(rd, 32'h08010003);
		@(negedge rclk);
		rctl <= 6'h18;
		while (q.size() > 0) begin
			@(negedge pclk);
			last = q.pop_front();
			cmp_bit(flags.output_ready, 1'b1);
			cmp_data(read_data, last);
			@(negedge rclk);
		end
		@(negedge rclk);
		rctl <= 6'h20;
		@(negedge pclk);
		cmp_data(read_data, last);
		cmp_bit(flags.output_ready, 1'b0);
		repeat (40) @(posedge pclk);
		cmp_flags(flags, 4'b0011);
		// retransmit: mark, two reads, reload the mark, leave the mode, drain
		repeat (4) wr(4'h6, 1'b1);
		repeat (40) @(posedge pclk);
		last = q.pop_front();
		cmp_data(read_data, last);
		cmp_flags(flags, 4'b1011);
		m.push_back(last);
		rd_edge(6'h22);
		repeat (2) begin
			rd_edge(6'h1A);
			last = q.pop_front();
			m.push_back(last);
			cmp_data(read_data, last);
		end
		cmp_flags(flags, 4'b1001);
		apb(1'b0, 12'h008, 32'h0);
		cmp_reg(rd, 32'h00020019);
		rd_edge(6'h23);
		cmp_data(read_data, m[0]);
		cmp_bit(flags.output_ready, 1'b1);
		q = {m[1:$], q};
		rd_edge(6'h20);
		repeat (30) @(posedge pclk);
		apb(1'b0, 12'h008, 32'h0);
		cmp_reg(rd, 32'h0004000D);
		while (q.size() > 0) begin
			rd_edge(6'h18);
			last = q.pop_front();
			cmp_data(read_data, last);
		end
		cmp_flags(flags, 4'b1011);
		finish_test();
	end
endmodule : tb
`default_nettype wire
